/* File: sysrst_pkg.sv */
// Constants and carrier types for the reset and interrupt controller
`default_nettype none
package sysrst_pkg;

  // Register map
  localparam logic [15:0] CAUSE_OFF = 16'hFE01;
  localparam logic [15:0] INTERRUPT_FLAGS_REG_ONE_OFF = 16'hFE04;
  localparam logic [15:0] CFG_OFF = 16'hFE09;
  localparam logic [15:0] WDOG_SVC_OFF = 16'hFFFF;

  // Reset cause register bit positions
  localparam int CB_POR = 7;
  localparam int CB_PIN = 6;
  localparam int CB_COP = 5;
  localparam int CB_ILLEGAL_OPCODE_FLAG = 4;
  localparam int CB_ILLEGAL_ADDRESS_FLAG = 3;
  localparam int CB_LVI = 1;
  localparam logic [7:0] CAUSE_RST = 8'h80;

  // Configuration register one fields
  localparam int CFG_STOPEN = 0;
  localparam int CFG_SHORT_STOP_RECOVERY_BIT = 1;
  localparam logic [7:0] CFG_MASK = 8'h03;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_FLAGS_REG_ONE_RST = 8'h00;

  // Widths
  localparam int PRESC_W = 12;
  localparam int SEQ_W = 13;
  localparam int WDOG_W = 6;
  localparam int N_SRC = 6;
  localparam int SVC_LO = 5;

  // Timing counts in internal clock cycles
  localparam int INT_PIN_CYC = 32;
  localparam int HOLD_CYC = 32;
  localparam int LV_BASE_CYC = 4096;
  localparam int STOP_LONG_CYC = 4096;
  localparam int STOP_SHORT_CYC = 32;
  localparam int TICK_MAX_CYC = 2**13 - 2**4;

  typedef enum logic [3:0] {
    SEQ_RUN  = 4'b0001,
    SEQ_PIN  = 4'b0010,
    SEQ_HOLD = 4'b0100,
    SEQ_STOP = 4'b1000
  } seq_t;

  typedef struct packed {
    logic rst_low;
    logic rst_vtst;
    logic irq_vtst;
  } pins_t;

  typedef struct packed {
    logic instr_done;
    logic i_mask;
    logic illegal_instr;
    logic stop_instr;
    logic swi_instr;
    logic opcode_fetch;
    logic unmapped;
    logic int_ack;
    logic wake;
  } cpu_in_t;

  typedef struct packed {
    logic monitor_mode;
    logic break_state;
    logic lvd_trip;
    logic mon_entry_rst;
  } mod_in_t;

  typedef struct packed {
    logic internal_reset_signal;
    logic bus_clk_en;
    logic int_req;
    logic [2:0] int_src;
    logic entry;
    logic set_mask;
    logic push_pc_minus1;
    logic push_h;
  } cpu_out_t;

  typedef struct packed {
    seq_t seq;
    logic [SEQ_W-1:0] seq_cnt;
    logic [PRESC_W-1:0] presc;
    logic [WDOG_W-1:0] wdog;
    logic [7:0] cause;
    logic [7:0] cfg;
    logic [7:0] interrupt_flags_reg_one;
    logic latched;
    logic [2:0] lat_idx;
    logic ent;
    logic ent_swi;
    logic short_stop_recovery_bit;
    logic woken;
    logic [7:0] rdata;
    pins_t sync1;
    pins_t sync2;
  } state_t;

endpackage
`default_nettype wire

/* File: system_reset_and_interrupt_ctrl.sv */
// Reset sequencer, prescaler, watchdog and interrupt latch
// How it works
// - Watchdog overflow raises internal reset and sets the watchdog cause flag.
// - Prescaler ticks the watchdog at least every 2^13 - 2^4 cycles.
// - Watchdog disabled by test voltage on either pin in monitor mode, two cycles after the pin via the synchroniser.
// - In break state, test voltage on reset pin disables the watchdog.
// - Illegal instruction sets illegal-opcode flag and raises reset.
// - Stop with stop-enable clear counts as illegal opcode.
// - Only an opcode fetch from unmapped space resets, data fetches do not.
// - Every internal reset source drives the reset pin low.
// - Low-voltage reset sets its flag, pin low 4096+32, then 32 more.
// - Monitor-entry reset input causes an internal reset.
// - Twelve-bit prescaler; its overflow clocks the watchdog.
// - Stop instruction clears the prescaler.
// - Stop exit samples short-recovery bit: wait 32 or 4096 cycles.
// - External pin reset leaves the prescaler alone; it runs after reset.
// - Latched interrupt keeps precedence until serviced.
// - Hardware interrupt starts after instruction end, mask clear, enabled.
// - Highest-priority pending source is serviced first.
// - Entry stacks registers and sets the mask, high index not pushed.
// - Software interrupt ignores mask and pushes PC, hardware pushes PC-1.
// - Status register one shows flags 6..1 in bits 7..2, low bits zero.
// - Every reset source asserts internal reset to default the system.
// - Internal resets other than low voltage drive the pin low 32 cycles, then hold 32 more.
//
// Implementation choice: the strobed register port.
`default_nettype none
module system_reset_and_interrupt_ctrl
  import sysrst_pkg::*;
#(
  parameter int LV_PIN_CYC = LV_BASE_CYC + INT_PIN_CYC
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Pins, unsynchronised
  input wire pins_t pins,
  // Reset pin driver
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  // Module and CPU signals
  input wire mod_in_t mods,
  input wire cpu_in_t cpu,
  input wire logic [N_SRC-1:0] irq_pend,
  input wire logic [N_SRC-1:0] irq_en,
  output cpu_out_t cpu_out,
  output logic wdog_enable
);

  localparam logic [SEQ_W-1:0] LV_LOAD = SEQ_W'(LV_PIN_CYC - 1);
  localparam logic [SEQ_W-1:0] PIN_LOAD = SEQ_W'(INT_PIN_CYC - 1);
  localparam logic [SEQ_W-1:0] HOLD_LOAD = SEQ_W'(HOLD_CYC - 1);
  localparam logic [PRESC_W-1:0] STOP_LONG_END =
    PRESC_W'(STOP_LONG_CYC - 1);
  localparam logic [PRESC_W-1:0] STOP_SHORT_END =
    PRESC_W'(STOP_SHORT_CYC - 1);

  state_t s;
  state_t n;
  pins_t p;
  logic wdog_dis;
  logic ext_rst;
  logic run;
  logic presc_adv;
  logic tick;
  logic wdog_ovf;
  logic svc;
  logic stop_ok;
  logic illegal_opcode_flag;
  logic illegal_address_flag;
  logic src_any;
  logic [N_SRC-1:0] qual;

  // Index of highest-priority source; source 1 ranks first
  function automatic logic [2:0] first_src(input logic [N_SRC-1:0] q);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (q[i]) begin
        idx = 3'(i + 1);
      end
    end
    return idx;
  endfunction

  always_comb begin
    n = s;
    p = s.sync2;
    n.sync1 = pins;
    n.sync2 = s.sync1;
    run = (s.seq == SEQ_RUN);
    // Own pin drive echoes through the synchroniser for two cycles
    ext_rst = p.rst_low && (s.seq != SEQ_PIN) &&
      !(s.seq == SEQ_HOLD && s.seq_cnt >= HOLD_LOAD - 1'b1);
    wdog_dis = (mods.monitor_mode & (p.rst_vtst | p.irq_vtst)) |
      (mods.break_state & p.rst_vtst);
    svc = wr & (addr == WDOG_SVC_OFF) & run;
    stop_ok = s.cfg[CFG_STOPEN];
    illegal_opcode_flag = cpu.illegal_instr | (cpu.stop_instr & ~stop_ok);
    illegal_address_flag = cpu.opcode_fetch & cpu.unmapped;
    presc_adv = (s.seq != SEQ_STOP) | s.woken;
    tick = presc_adv & (s.presc == '1);
    wdog_ovf = run & ~wdog_dis & tick & (s.wdog == '1) & ~svc;
    src_any = mods.lvd_trip | wdog_ovf | illegal_opcode_flag | illegal_address_flag | mods.mon_entry_rst;
    if (s.seq == SEQ_STOP) begin
      src_any = mods.lvd_trip;
    end else if (!run) begin
      src_any = 1'b0;
    end
    qual = irq_pend & irq_en;

    // Free-running prescaler, untouched by external pin reset
    if (presc_adv) begin
      n.presc = s.presc + 1'b1;
    end
    if (run && !wdog_dis && tick) begin
      n.wdog = s.wdog + 1'b1;
    end
    if (svc) begin
      n.wdog = '0;
      n.presc[PRESC_W-1:SVC_LO] = '0;
      n.presc[SVC_LO-1:0] = s.presc[SVC_LO-1:0] + 1'b1;
    end

    // Status register mirrors pending flags
    n.interrupt_flags_reg_one = {irq_pend, 2'b00};

    // Interrupt latch and entry
    n.ent = 1'b0;
    if (s.latched && cpu.int_ack) begin
      n.latched = 1'b0;
    end
    if (run && !ext_rst) begin
      if (cpu.swi_instr) begin
        n.ent = 1'b1;
        n.ent_swi = 1'b1;
      end else if (cpu.instr_done && !cpu.i_mask && !s.latched &&
                   (qual != '0)) begin
        n.latched = 1'b1;
        n.lat_idx = first_src(qual);
        n.ent = 1'b1;
        n.ent_swi = 1'b0;
      end
    end

    // Configuration write
    if (wr && addr == CFG_OFF) begin
      n.cfg = wdata & CFG_MASK;
    end

    // Read data valid in the cycle after the strobe only
    n.rdata = 8'h00;
    if (rd) begin
      case (addr)
        CAUSE_OFF: n.rdata = s.cause;
        INTERRUPT_FLAGS_REG_ONE_OFF: n.rdata = s.interrupt_flags_reg_one;
        CFG_OFF: n.rdata = s.cfg;
        default: n.rdata = 8'h00;
      endcase
    end

    // Reset and stop sequencer
    case (s.seq)
      SEQ_RUN: begin
        if (cpu.stop_instr && stop_ok && !src_any) begin
          n.seq = SEQ_STOP;
          n.presc = '0;
          n.woken = 1'b0;
        end
      end
      SEQ_STOP: begin
        if (!s.woken && (cpu.wake || ext_rst)) begin
          n.woken = 1'b1;
          n.short_stop_recovery_bit = s.cfg[CFG_SHORT_STOP_RECOVERY_BIT];
        end else if (s.woken && s.presc ==
                     (s.short_stop_recovery_bit ? STOP_SHORT_END : STOP_LONG_END)) begin
          n.seq = SEQ_RUN;
          n.woken = 1'b0;
        end
      end
      SEQ_PIN: begin
        n.seq_cnt = s.seq_cnt - 1'b1;
        if (s.seq_cnt == '0) begin
          n.seq = SEQ_HOLD;
          n.seq_cnt = HOLD_LOAD;
        end
      end
      SEQ_HOLD: begin
        n.seq_cnt = s.seq_cnt - 1'b1;
        if (s.seq_cnt == '0) begin
          n.seq = SEQ_RUN;
        end
      end
      default: n.seq = SEQ_RUN;
    endcase

    // Internal reset sources, low voltage first
    if (src_any) begin
      n.seq = SEQ_PIN;
      n.seq_cnt = PIN_LOAD;
      n.cause = 8'h00;
      if (mods.lvd_trip) begin
        n.cause[CB_LVI] = 1'b1;
        n.seq_cnt = LV_LOAD;
      end else if (wdog_ovf) begin
        n.cause[CB_COP] = 1'b1;
      end else if (illegal_opcode_flag) begin
        n.cause[CB_ILLEGAL_OPCODE_FLAG] = 1'b1;
      end else if (illegal_address_flag) begin
        n.cause[CB_ILLEGAL_ADDRESS_FLAG] = 1'b1;
      end
      n.presc = '0;
      n.wdog = '0;
      n.cfg = CFG_RST;
    end

    // Any reset returns interrupt and watchdog state to defaults
    if (src_any || ext_rst || !run) begin
      n.latched = 1'b0;
      n.lat_idx = 3'h0;
      n.interrupt_flags_reg_one = INTERRUPT_FLAGS_REG_ONE_RST;
    end
    if (ext_rst && s.seq != SEQ_PIN) begin
      n.cause = 8'h00;
      n.cause[CB_PIN] = 1'b1;
      n.wdog = '0;
      n.cfg = CFG_RST;
      if (s.seq == SEQ_HOLD) begin
        n.seq = SEQ_RUN;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s.seq <= SEQ_PIN;
      s.seq_cnt <= LV_LOAD;
      s.presc <= '0;
      s.wdog <= '0;
      s.cause <= CAUSE_RST;
      s.cfg <= CFG_RST;
      s.interrupt_flags_reg_one <= INTERRUPT_FLAGS_REG_ONE_RST;
      s.latched <= 1'b0;
      s.lat_idx <= 3'h0;
      s.ent <= 1'b0;
      s.ent_swi <= 1'b0;
      s.short_stop_recovery_bit <= 1'b0;
      s.woken <= 1'b0;
      s.rdata <= 8'h00;
      s.sync1 <= '0;
      s.sync2 <= '0;
    end else begin
      s <= n;
    end
  end

  // Open drain: only ever pulls low
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = (s.seq != SEQ_PIN);
  assign rdata = s.rdata;
  assign wdog_enable = ~wdog_dis;
  assign cpu_out.internal_reset_signal = (s.seq == SEQ_PIN) | (s.seq == SEQ_HOLD) |
    ext_rst;
  assign cpu_out.bus_clk_en = run;
  assign cpu_out.int_req = s.latched;
  assign cpu_out.int_src = s.lat_idx;
  assign cpu_out.entry = s.ent;
  assign cpu_out.set_mask = s.ent;
  assign cpu_out.push_pc_minus1 = s.ent & ~s.ent_swi;
  assign cpu_out.push_h = 1'b0;

  // Checks
  logic [SEQ_W-1:0] gap_r;
  logic [SEQ_W-1:0] gap_nxt;
  always_comb begin
    gap_nxt = gap_r + 1'b1;
    if (tick || !run || svc) begin
      gap_nxt = '0;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wdog_reset_a: assert property (
    wdog_ovf && !mods.lvd_trip |=> s.seq == SEQ_PIN && s.cause[CB_COP])
    else $error("watchdog overflow did not reset");
  wdog_service_a: assert property (
    svc && !src_any |=> s.wdog == '0 && s.presc[PRESC_W-1:SVC_LO] == '0)
    else $error("watchdog service did not clear counters");
  tick_gap_a: assert property (
    gap_r < SEQ_W'(TICK_MAX_CYC))
    else $error("watchdog tick gap too long");
  mon_disable_a: assert property (
    run && wdog_dis && !svc && !src_any && !ext_rst |=> $stable(s.wdog))
    else $error("disabled watchdog advanced");
  break_disable_a: assert property (
    mods.break_state && p.rst_vtst |-> !wdog_enable)
    else $error("break state left watchdog enabled");
  illegal_opcode_flag_reset_a: assert property (
    run && cpu.stop_instr && !stop_ok && !mods.lvd_trip && !wdog_ovf
    |=> s.seq == SEQ_PIN && s.cause[CB_ILLEGAL_OPCODE_FLAG])
    else $error("stop while disabled did not reset");
  data_fetch_a: assert property (
    run && cpu.unmapped && !cpu.opcode_fetch && !illegal_opcode_flag && !wdog_ovf &&
    !mods.lvd_trip && !mods.mon_entry_rst && !cpu.stop_instr
    |=> s.seq == SEQ_RUN)
    else $error("data fetch caused reset");
  pin_drive_a: assert property (
    src_any |=> !rst_pin_oe_n ##1 !rst_pin_oe_n)
    else $error("reset pin not driven");
  hold_time_a: assert property (
    $rose(s.seq == SEQ_HOLD) |-> cpu_out.internal_reset_signal [*8] ##24
    s.seq == SEQ_HOLD ##1 s.seq == SEQ_RUN)
    else $error("internal reset hold not 32 cycles");
  latch_keep_a: assert property (
    s.latched && !cpu.int_ack && run && !ext_rst && !src_any
    |=> s.latched && $stable(s.lat_idx))
    else $error("latched interrupt lost precedence");
  swi_push_a: assert property (
    run && !ext_rst && cpu.swi_instr |=> s.ent && !cpu_out.push_pc_minus1)
    else $error("software interrupt pushed PC-1");
  stop_clear_a: assert property (
    run && cpu.stop_instr && stop_ok && !src_any
    |=> s.seq == SEQ_STOP && s.presc == '0)
    else $error("stop did not clear prescaler");
  lvd_reset_a: assert property (
    run && mods.lvd_trip |=> s.seq == SEQ_PIN && s.cause[CB_LVI] &&
    s.seq_cnt == LV_LOAD)
    else $error("low-voltage reset not started");
  mon_entry_a: assert property (
    run && mods.mon_entry_rst |=> s.seq == SEQ_PIN)
    else $error("monitor-entry reset ignored");
  interrupt_flags_reg_one_view_a: assert property (
    run && !ext_rst && !src_any |=> s.interrupt_flags_reg_one == {$past(irq_pend), 2'b00})
    else $error("status register does not show pending flags");

endmodule
`default_nettype wire

/* File: cpu_partner.sv */
// CPU-side model that services a latched interrupt after a delay
`default_nettype none
module cpu_partner
  import sysrst_pkg::*;
#(
  parameter int DLY = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Controller side
  input wire cpu_out_t cpu_out,
  output logic int_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Entry stacks state; the service routine ends with an acknowledge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      int_ack <= 1'b0;
    end else begin
      int_ack <= 1'b0;
      if (cpu_out.entry === 1'b1) begin
        cnt <= DLY;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        int_ack <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: system_reset_and_interrupt_ctrl_bench.sv */
// Self-checking bench for the reset and interrupt controller
`default_nettype none
module system_reset_and_interrupt_ctrl_bench;
  import sysrst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LVP = 40;
  logic clk, rstn, wr, rd, ack, pin_out, oe_n, wd_en, vt_r, vt_i, ext_low;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic [N_SRC-1:0] pend, en;
  pins_t pins;
  mod_in_t mods;
  cpu_in_t cpu, cpu_d;
  cpu_out_t co;
  int fails, checked, pc, hc, n;
  int cyc = 0;

  system_reset_and_interrupt_ctrl #(.LV_PIN_CYC(LVP)) u_dut (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pins(pins), .rst_pin_out(pin_out),
    .rst_pin_oe_n(oe_n), .mods(mods), .cpu(cpu), .irq_pend(pend),
    .irq_en(en), .cpu_out(co), .wdog_enable(wd_en));
  cpu_partner u_cpu (.clk(clk), .rstn(rstn), .cpu_out(co), .int_ack(ack));

  // Reset pin has a pull-up: low while the device or the external driver ext_low pulls it
  always_comb begin
    pins = '{rst_low: !oe_n || ext_low, rst_vtst: vt_r, irq_vtst: vt_i};
    cpu = cpu_d;
    cpu.int_ack = ack;
  end

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Bit order: done mask illegal_instr stop swi fetch unmapped ack wake
  task automatic pulse(input cpu_in_t v);
    @(posedge clk);
    cpu_d <= v;
    @(posedge clk);
    cpu_d <= '0;
    #1;
  endtask

  task automatic pulse_mod(input mod_in_t v);
    @(posedge clk);
    mods <= v;
    @(posedge clk);
    mods <= '0;
    #1;
  endtask

  task automatic meas();
    n = 0;
    pc = 0;
    hc = 0;
    while (oe_n !== 1'b0 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (oe_n === 1'b0 && pc < 5000) begin
      @(posedge clk);
      #1;
      pc++;
    end
    while (co.internal_reset_signal === 1'b1 && hc < 100) begin
      @(posedge clk);
      #1;
      hc++;
    end
  endtask

  task automatic expect_rst(input int pin_exp, input logic [7:0] cause);
    meas();
    chk(16'(pc), 16'(pin_exp));
    chk(pin_out, 1'b0);
    chk(16'(hc), 16'(HOLD_CYC));
    chk(co.bus_clk_en, 1'b1);
    rd_chk(CAUSE_OFF, cause);
  endtask

  task automatic wait_idle();
    n = 0;
    while (co.int_req !== 1'b0 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(co.int_req, 1'b0);
  endtask

  task automatic wd_case(input mod_in_t m, input logic r, input logic i,
                         input logic exp);
    @(posedge clk);
    mods <= m;
    vt_r <= r;
    vt_i <= i;
    repeat (4) @(posedge clk);
    #1;
    chk(wd_en, exp);
  endtask

  task automatic t_reset();
    meas();
    chk(16'(hc), 16'(HOLD_CYC));
    rd_chk(CAUSE_OFF, CAUSE_RST);
    rd_chk(INTERRUPT_FLAGS_REG_ONE_OFF, INTERRUPT_FLAGS_REG_ONE_RST);
    rd_chk(16'h0F00, 8'h00);
  endtask

  task automatic t_wdog();
    wr_reg(WDOG_SVC_OFF, 8'hA5);
    wd_case(4'b1000, 1'b1, 1'b0, 1'b0);
    wd_case(4'b1000, 1'b0, 1'b1, 1'b0);
    wd_case(4'b0100, 1'b1, 1'b0, 1'b0);
    wd_case(4'b0000, 1'b1, 1'b1, 1'b1);
    wd_case(4'b0000, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic t_irq();
    @(posedge clk);
    pend <= 6'b000110;
    pulse(9'h100);
    chk(co.entry, 1'b1);
    chk(co.int_src, 3'd2);
    chk(co.push_pc_minus1, 1'b1);
    chk(co.set_mask, 1'b1);
    chk(co.push_h, 1'b0);
    rd_chk(INTERRUPT_FLAGS_REG_ONE_OFF, 8'h18);
    @(posedge clk);
    pend <= 6'b000111;
    pulse(9'h100);
    chk(co.int_src, 3'd2);
    wait_idle();
    pulse(9'h180);
    chk(co.entry, 1'b0);
    pulse(9'h190);
    chk(co.entry, 1'b1);
    chk(co.push_pc_minus1, 1'b0);
    wait_idle();
    @(posedge clk);
    pend <= 6'b000001;
    en <= 6'b111110;
    pulse(9'h100);
    chk(co.entry, 1'b0);
    @(posedge clk);
    en <= '1;
    pend <= '0;
  endtask

  task automatic t_faults();
    pulse(9'h040);
    expect_rst(INT_PIN_CYC, 8'h10);
    pulse(9'h020);
    expect_rst(INT_PIN_CYC, 8'h10);
    pulse(9'h004);
    repeat (4) @(posedge clk);
    #1;
    chk(oe_n, 1'b1);
    pulse(9'h00C);
    expect_rst(INT_PIN_CYC, 8'h08);
    pulse_mod(4'b0010);
    expect_rst(LVP, 8'h02);
    pulse_mod(4'b0001);
    expect_rst(INT_PIN_CYC, 8'h00);
  endtask

  task automatic stop_run(input logic [7:0] c, input int exp);
    wr_reg(CFG_OFF, c);
    rd_chk(CFG_OFF, c);
    pulse(9'h020);
    chk(co.bus_clk_en, 1'b0);
    repeat (10) @(posedge clk);
    pulse(9'h001);
    n = 0;
    while (co.bus_clk_en !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(exp));
  endtask

  task automatic t_stop();
    stop_run(8'h03, STOP_SHORT_CYC);
    stop_run(8'h01, STOP_LONG_CYC);
  endtask

  // External pin reset: internal reset follows the pin, cause is pin only
  task automatic t_pin();
    @(posedge clk);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(co.internal_reset_signal, 1'b1);
    @(posedge clk);
    ext_low <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk(co.internal_reset_signal, 1'b0);
    rd_chk(CAUSE_OFF, 8'h40);
    rd_chk(CFG_OFF, CFG_RST);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    fails = 0;
    checked = 0;
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    vt_r = 1'b0;
    vt_i = 1'b0;
    mods = '0;
    cpu_d = '0;
    pend = '0;
    en = '1;
    ext_low = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_wdog();
    t_irq();
    t_faults();
    t_stop();
    t_pin();
    finish_test();
  end
endmodule
`default_nettype wire
